/* hdl/ewp_host.sv */
// Host controller that loads a page into a parallel EEPROM and polls for completion
`timescale 1ns/1ps
// How it works
// - Load one to sixty-four bytes per page
// - Keep page address steady on each strobe
// - Output enable high while writing
// - Pulse output enable to make read strobes
// - Done when two reads agree on toggle
// - Poll at one constant address
//
// The user first issues the code sequence bytes as ordinary bytes (last flagged),
// then page bytes; after the last byte the host polls the toggle bit.
module ewp_host (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       byte_valid,
  input  wire ewp_pkg::ewp_byte_t         byte_in,
  input  wire logic                       byte_last,
  output logic                            byte_ready,
  output logic                            write_done,
  output logic                            busy,
  output ewp_pkg::ewp_pins_t              pins,
  input  wire logic [ewp_pkg::DATA_W-1:0] dq_in
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    ewp_pkg::ewp_phase_t             phase;     // Current phase
    logic [ewp_pkg::TMR_W-1:0]       tmr;       // Phase timer
    logic [ewp_pkg::CNT_W-1:0]       cnt;       // Bytes in this page
    logic [ewp_pkg::ADDR_W-1:0]      page;      // Page address latched
    logic                            last;      // Last byte flag held
    logic                            have_prev; // One poll read taken
    logic                            prev_tog;  // Toggle bit of last read
    ewp_pkg::ewp_pins_t              pins;      // Pin outputs
    logic                            ready;     // Byte accept
    logic                            done;      // Completion pulse
    logic                            busy;      // Operation in progress
  } ewp_state_t;

  ewp_state_t                  st_reg;          // Registered state
  ewp_state_t                  st_next;         // Next state
  logic [ewp_pkg::DATA_W-1:0]  dq_s1_reg;       // Sync stage one
  logic [ewp_pkg::DATA_W-1:0]  dq_s2_reg;       // Sync stage two

  // Page field of an address
  function automatic logic [ewp_pkg::ADDR_W-1:0] page_of(input logic [ewp_pkg::ADDR_W-1:0] a);
    page_of = (a >> ewp_pkg::PAGE_LO) << ewp_pkg::PAGE_LO;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Data input synchroniser
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dq_s1_reg <= ewp_pkg::DATA_RST;
      dq_s2_reg <= ewp_pkg::DATA_RST;
    end else begin
      dq_s1_reg <= dq_in;
      dq_s2_reg <= dq_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.ready = 1'b0;
    unique case (st_reg.phase)
      // Wait for a byte; write strobes only, read disabled
      ewp_pkg::EWP_IDLE: begin
        st_next.pins.oe_n = 1'b1;
        st_next.pins.ce_n = 1'b1;
        st_next.pins.we_n = 1'b1;
        st_next.pins.dq_oe = 1'b0;
        if (byte_valid && st_reg.ready) begin
          // Page address must not change within a page
          if (st_reg.cnt == '0) begin
            st_next.page = page_of(byte_in.addr);
          end
          st_next.pins.addr = (st_reg.cnt == '0) ? byte_in.addr :
                              (st_reg.page | (byte_in.addr ^ page_of(byte_in.addr)));
          st_next.pins.dq_out = byte_in.data;
          st_next.pins.dq_oe = 1'b1;
          st_next.pins.ce_n = 1'b0;
          st_next.pins.we_n = 1'b0;
          st_next.pins.oe_n = 1'b1;
          st_next.last = byte_last ||
                         (st_reg.cnt == 7'(ewp_pkg::PAGE_BYTES - 1));
          st_next.cnt = st_reg.cnt + 7'h01;
          st_next.tmr = 8'(ewp_pkg::WP_CYC);
          st_next.busy = 1'b1;
          st_next.phase = ewp_pkg::EWP_WR_LOW;
        end else begin
          st_next.ready = 1'b1;
        end
      end
      // Strobe low for the pulse width
      ewp_pkg::EWP_WR_LOW: begin
        st_next.tmr = st_reg.tmr - 8'h01;
        if (st_reg.tmr == 8'h01) begin
          st_next.pins.we_n = 1'b1;
          st_next.pins.ce_n = 1'b1;
          st_next.tmr = 8'(ewp_pkg::WPH_CYC);
          st_next.phase = ewp_pkg::EWP_WR_HIGH;
        end
      end
      // Strobe high; next byte or start polling
      ewp_pkg::EWP_WR_HIGH: begin
        st_next.tmr = st_reg.tmr - 8'h01;
        if (st_reg.tmr == 8'h01) begin
          st_next.pins.dq_oe = 1'b0;
          if (st_reg.last) begin
            // Poll at the last written address held constant
            st_next.have_prev = 1'b0;
            st_next.tmr = 8'(ewp_pkg::OEHP_CYC);
            st_next.phase = ewp_pkg::EWP_RD_HIGH;
          end else begin
            st_next.ready = 1'b1;
            st_next.phase = ewp_pkg::EWP_IDLE;
          end
        end
      end
      // Output enable high between read strobes
      ewp_pkg::EWP_RD_HIGH: begin
        st_next.tmr = st_reg.tmr - 8'h01;
        if (st_reg.tmr == 8'h01) begin
          st_next.pins.oe_n = 1'b0;
          st_next.pins.ce_n = 1'b0;
          st_next.tmr = 8'(ewp_pkg::ACC_CYC + 2);
          st_next.phase = ewp_pkg::EWP_RD_LOW;
        end
      end
      // Sample toggle bit; two equal reads end the write
      ewp_pkg::EWP_RD_LOW: begin
        st_next.tmr = st_reg.tmr - 8'h01;
        if (st_reg.tmr == 8'h01) begin
          st_next.pins.oe_n = 1'b1;
          st_next.pins.ce_n = 1'b1;
          st_next.prev_tog = dq_s2_reg[ewp_pkg::TOGGLE_BIT];
          st_next.have_prev = 1'b1;
          st_next.tmr = 8'(ewp_pkg::OEHP_CYC);
          if (st_reg.have_prev &&
              st_reg.prev_tog == dq_s2_reg[ewp_pkg::TOGGLE_BIT]) begin
            // Arm, disarm or page write all end here
            st_next.phase = ewp_pkg::EWP_DONE;
          end else begin
            st_next.phase = ewp_pkg::EWP_RD_HIGH;
          end
        end
      end
      // Report completion and re-open for a new page
      ewp_pkg::EWP_DONE: begin
        st_next.done = 1'b1;
        st_next.busy = 1'b0;
        st_next.cnt = '0;
        st_next.last = 1'b0;
        st_next.ready = 1'b1;
        st_next.phase = ewp_pkg::EWP_IDLE;
      end
      default: begin
        st_next.phase = ewp_pkg::EWP_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.phase <= ewp_pkg::EWP_IDLE;
      st_reg.pins.ce_n <= 1'b1;
      st_reg.pins.oe_n <= 1'b1;
      st_reg.pins.we_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins = st_reg.pins;
  assign byte_ready = st_reg.ready;
  assign write_done = st_reg.done;
  assign busy = st_reg.busy;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_oe_high_in_write;
    @(posedge clk) disable iff (reset)
      (!st_reg.pins.we_n && !st_reg.pins.ce_n) |-> st_reg.pins.oe_n;
  endproperty
  a_oe_high_in_write: assert property (p_oe_high_in_write)
    else $error("output enable low during write strobe");

  property p_page_steady;
    @(posedge clk) disable iff (reset)
      ($fell(st_reg.pins.we_n) && st_reg.cnt > 7'h01) |->
        page_of(st_reg.pins.addr) == st_reg.page;
  endproperty
  a_page_steady: assert property (p_page_steady)
    else $error("page address changed inside a page");

  property p_count_limit;
    @(posedge clk) disable iff (reset)
      st_reg.cnt <= 7'(ewp_pkg::PAGE_BYTES);
  endproperty
  a_count_limit: assert property (p_count_limit)
    else $error("page byte count above limit");

  property p_addr_steady_poll;
    @(posedge clk) disable iff (reset)
      (st_reg.phase == ewp_pkg::EWP_RD_LOW) |-> $stable(st_reg.pins.addr);
  endproperty
  a_addr_steady_poll: assert property (p_addr_steady_poll)
    else $error("poll address moved");

  property p_done_needs_match;
    @(posedge clk) disable iff (reset)
      $rose(st_reg.done) |-> $past(st_reg.have_prev, 2);
  endproperty
  a_done_needs_match: assert property (p_done_needs_match)
    else $error("completion without two reads");

  property p_pulse_width;
    @(posedge clk) disable iff (reset)
      $fell(st_reg.pins.we_n) |-> (!st_reg.pins.we_n) [*8];
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("write pulse too short");

  property p_read_strobe;
    @(posedge clk) disable iff (reset)
      $rose(st_reg.pins.oe_n) && st_reg.phase == ewp_pkg::EWP_RD_HIGH |->
        st_reg.pins.oe_n [*8];
  endproperty
  a_read_strobe: assert property (p_read_strobe)
    else $error("read strobe high pulse too short");

  property p_no_drive_read;
    @(posedge clk) disable iff (reset)
      !st_reg.pins.oe_n |-> !st_reg.pins.dq_oe;
  endproperty
  a_no_drive_read: assert property (p_no_drive_read)
    else $error("host drives data while reading");

  c_done: cover property (@(posedge clk) disable iff (reset) $rose(st_reg.done));
  c_full_page: cover property (@(posedge clk) disable iff (reset)
    st_reg.cnt == 7'(ewp_pkg::PAGE_BYTES));
  c_poll_repeat: cover property (@(posedge clk) disable iff (reset)
    st_reg.have_prev && st_reg.phase == ewp_pkg::EWP_RD_LOW);
endmodule

/* shared/ewp_pkg.sv */
// Shared constants and carrier types for the EEPROM protected-write host controller
package ewp_pkg;
  // Pin widths, page size and counter width
  localparam int ADDR_W = 13;                 // Address pins
  localparam int DATA_W = 8;                  // Data pins
  localparam int PAGE_BYTES = 64;             // Largest page load
  localparam int CNT_W = 7;                   // Byte counter width
  // Bit positions of the status bits on the data bus
  localparam int TOGGLE_BIT = 6;              // Toggle status bit position
  localparam int POLL_BIT = 7;                // Polling status bit position
  // Page address field position
  localparam int PAGE_LO = 6;                 // Lowest page address bit
  // Clock and timing
  localparam int CLK_PERIOD_NS = 4;           // 250 MHz clock period
  localparam int WP_NS = 100;                 // Least write pulse width
  localparam int WPH_NS = 50;                 // Least write pulse high time
  localparam int OEHP_NS = 150;               // Least output enable high pulse
  localparam int ACC_NS = 120;                // Longest access delay assumed
  localparam int WP_CYC = (WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC = (WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OEHP_CYC = (OEHP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = (ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 8;                   // Phase timer width
  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // Host controller phases
  typedef enum logic [3:0] {
    EWP_IDLE, EWP_WR_LOW, EWP_WR_HIGH, EWP_RD_HIGH, EWP_RD_LOW, EWP_DONE
  } ewp_phase_t;

  // One byte to place on the bus
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ewp_byte_t;

  // Pins driven toward the memory
  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
  } ewp_pins_t;
endpackage

/* verification/ewp_mem_model.sv */
// Behavioural model of the byte-wide EEPROM that the host controller drives
`timescale 1ns/1ps
module ewp_mem_model #(
  parameter int                BLC_CYC   = 100,      // Idle cycles that close a byte load
  parameter logic [12:0]       CODE_ADDR = 13'h1555  // Arbitrary stand-in for the code address
) (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire ewp_pkg::ewp_pins_t pins,
  input  wire logic [11:0]        wr_len,
  output logic [7:0]              dq_o,
  output logic                    wr_busy,
  output logic                    prot,
  output logic                    rule_err
);
  logic [7:0]  mem [0:8191];  // Array contents
  logic        wr;            // Write strobe active
  logic        rd;            // Read strobe active
  logic        wr_q;          // Write strobe, last cycle
  logic        rd_q;          // Read strobe, last cycle
  logic        loading;       // Byte load window open
  logic [6:0]  page;          // Page latched by first byte
  logic [7:0]  idle;          // Cycles since last strobe
  logic [11:0] wcnt;          // Internal write progress
  logic [7:0]  last;          // Last byte written
  logic        tog;           // Toggle status state
  logic [1:0]  pend;          // Pending protection change {valid, arm}
  logic [7:0]  held;          // Last value shown on the bus

  assign wr = !pins.ce_n && !pins.we_n;
  assign rd = !pins.ce_n && !pins.oe_n && pins.we_n;
  // Status during write, array after; a released bus shows the inverse of the last value
  assign dq_o = !rd ? ~held : wr_busy ? {~last[7], tog, last[5:0]}
                            : mem[pins.addr];

  ////////////////////////////////////////////////////////////////////////////////////////
  // Byte load, internal write timer, protection state and pin checks
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {wr_q, rd_q, loading, wr_busy, prot, rule_err, tog} <= '0;
      {page, idle, wcnt, last, pend, held} <= '0;
    end else begin
      wr_q <= wr;
      rd_q <= rd;
      // Only a driven read updates what a released bus inverts
      if (rd) held <= dq_o;
      if (wr && !wr_q) begin
        // New group latches the page and any code carried by its first byte
        if (!loading) begin
          page <= pins.addr[12:6];
          loading <= 1'b1;
          pend <= (pins.addr == CODE_ADDR) ? {1'b1, pins.dq_out[0]} : 2'b00;
        end else if (pins.addr[12:6] != page) begin
          rule_err <= 1'b1;
        end
        mem[pins.addr] <= pins.dq_out;
        last <= pins.dq_out;
        idle <= '0;
      end else if (loading) begin
        // Silence on the strobes, or a first read, starts the internal write
        idle <= idle + 8'h01;
        if (idle == 8'(BLC_CYC) || (rd && !rd_q)) begin
          loading <= 1'b0;
          wr_busy <= 1'b1;
          wcnt <= '0;
        end
      end
      if (wr_busy) begin
        wcnt <= wcnt + 12'h001;
        if (wcnt == wr_len) begin
          wr_busy <= 1'b0;
          if (pend[1]) prot <= pend[0];
        end
      end
      if (rd && !rd_q && wr_busy) tog <= ~tog;
      if (wr && !pins.oe_n) rule_err <= 1'b1;
    end
  end
endmodule

/* verification/test_ewp_host.sv */
// Self-checking testbench of the EEPROM host controller against the memory model
`timescale 1ns/1ps
module test_ewp_host;
  logic               clk = 1'b0;            // 250 MHz clock
  logic               reset = 1'b1;          // Async reset
  logic               byte_valid = 1'b0;     // Byte offered
  ewp_pkg::ewp_byte_t byte_in = '0;          // Address and data
  logic               byte_last = 1'b0;      // Ends the group
  logic               byte_ready;            // Host takes bytes
  logic               write_done;            // Poll finished
  logic               busy;                  // Host busy
  ewp_pkg::ewp_pins_t pins;                  // Memory pins
  logic [7:0]         dq_o;                  // Model data
  logic [7:0]         dq_in;                 // Resolved data bus
  logic [11:0]        wr_len = 12'h064;      // Internal write length
  logic               wr_busy;               // Model writing
  logic               prot;                  // Model protection state
  logic               rule_err;              // Model saw a pin fault
  logic [7:0]         exp_q [$];             // Expected {prot, count}
  logic [31:0]        seed = 32'h11;         // Xorshift state
  int                 bad_count = 0;         // Mismatches
  int                 checks = 0;            // Comparisons
  int                 acc = 0;               // Bytes taken this group
  int                 cyc = 0;               // Cycle counter

  always #2 clk = ~clk;
  // Host drives data while enabled, otherwise the model owns the bus
  assign dq_in = pins.dq_oe ? pins.dq_out : dq_o;

  ewp_host dut (.clk(clk), .reset(reset), .byte_valid(byte_valid), .byte_in(byte_in),
    .byte_last(byte_last), .byte_ready(byte_ready), .write_done(write_done), .busy(busy),
    .pins(pins), .dq_in(dq_in));
  ewp_mem_model mem (.clk(clk), .reset(reset), .pins(pins), .wr_len(wr_len), .dq_o(dq_o),
    .wr_busy(wr_busy), .prot(prot), .rule_err(rule_err));

  ////////////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One byte, held until the host takes it
  task automatic send_byte(logic [12:0] a, logic [7:0] d, logic l);
    int n;
    @(posedge clk);
    #1;
    byte_valid = 1'b1;
    byte_in = '{addr: a, data: d};
    byte_last = l;
    n = 0;
    // Ready is read one step after the edge, where it has settled
    while (byte_ready !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    // The host takes the byte at this edge
    @(posedge clk);
    #1;
    byte_valid = 1'b0;
    byte_last = 1'b0;
  endtask

  // A group of n bytes on one page, then the state expected at its end
  task automatic send_group(logic [12:0] a, int n, logic p);
    wr_len = 12'(100 + rnd() % 900);
    exp_q.push_back({p, 7'(n)});
    for (int i = 0; i < n; i++) begin
      // Later bytes carry random page bits that the host must replace
      send_byte(i == 0 ? a : {7'(rnd()), 6'(i)}, (i == 0 && a == 13'h1555) ? {7'h00, p}
                : 8'(rnd()), i == n - 1);
    end
    wait (exp_q.size() == 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  // Monitor: counts taken bytes and checks each completed poll
  always @(negedge clk) begin
    if (!reset) begin
      if (byte_valid && byte_ready) begin
        check("busy_take", busy, acc != 0);
        acc++;
      end
      if (write_done === 1'b1) begin
        check("bytes", acc, {25'h0, exp_q[0][6:0]});
        check("mem_busy", wr_busy, 1'b0);
        check("busy_done", busy, 1'b0);
        check("prot", prot, exp_q[0][7]);
        void'(exp_q.pop_front());
        acc = 0;
      end
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    #1;
    reset = 1'b0;
    @(posedge clk);
    send_group(13'h0040, 1, 1'b0);
    send_group(13'h1555, 1, 1'b1);
    send_group(13'h0200, 3, 1'b1);
    send_group(13'h1555, 1, 1'b0);
    send_group(13'h0A00, 64, 1'b0);
    send_group(13'h0400, 2 + rnd() % 20, 1'b0);
    check("pin_faults", rule_err, 1'b0);
    end_sim();
  end
endmodule
